// ==== common/lpmc_pkg.sv ====
/*
 * Constants, mode encoding and control carrier for the low-power mode controller.
 * Assumes a 20 MHz always-on controller clock and an APB register slave.
 */
// Functional notes
// - Deep-sleep instruction puts the device into deep sleep with its conditions.
// - Deep sleep stops crystal and precision oscillators, drives crystal pins low.
// - Deep sleep stops the system clock completely.
// - Deep sleep and halt stall the core and freeze the program counter.
// - Watchdog and its oscillator run in deep sleep only if enabled there.
// - Brown-out detector runs in deep sleep only when its option bit allows.
// - Comparators and reference keep running in deep sleep unless software disabled.
// - All other peripherals are idle during deep sleep.
// - Deep sleep is left only through the recovery sequence.
// - Halt instruction puts the device into halt mode.
// - Halt keeps crystal oscillator and system clock running.
// - Halt keeps watchdog oscillator running; watchdog counts only when enabled.
// - Halt keeps all other peripherals operating normally.
// - Interrupt, exception, watchdog, power-on, brown-out or pin reset end halt.
// - Halt recovery completes in under five microseconds.
// - Each defined power control bit disables its peripheral block.
// - Bit 4 clear enables brown-out detector; needs always-on option too.
// - Unused digital peripherals have clocks gated automatically.
// - Recovery holds reset for 66 oscillator cycles, touching only status.
// - Enabled GPIO level change in deep sleep starts recovery, sets flag.
// - Watchdog time-out in sleep starts recovery, sets both flags, exception follows; the code raises it only when wdt_is_reset_i is low.
package lpmc_pkg;

    // ==========================================================
    // Register map
    localparam logic [11:0] PWR_CTL0_OFF = 12'hF80;
    localparam logic [11:0] OPT_OFF      = 12'hF84;
    localparam logic [11:0] STAT_OFF     = 12'hF88;
    localparam logic [11:0] WAKE_EN_OFF  = 12'hF8C;
    localparam logic [7:0]  PWR_CTL0_RST = 8'h00;
    localparam logic [2:0]  OPT_RST      = 3'h0;
    localparam int          BOD_DIS_BIT  = 4;
    localparam int          OPT_WDT_SLP  = 0;
    localparam int          OPT_CMP_DIS  = 1;
    localparam int          OPT_VREF_DIS = 2;
    localparam int          ST_SLP_RCV   = 2;
    localparam int          ST_WDT_RCV   = 3;

    // ==========================================================
    // Timing
    localparam int SYS_CLK_NS     = 50;
    localparam int HALT_RECOV_NS  = 5000;
    localparam int HALT_RECOV_CYC = HALT_RECOV_NS / SYS_CLK_NS;
    localparam int RECOV_OSC_CYC  = 66;

    // ==========================================================
    // Modes and control carrier
    typedef enum logic [1:0] {
        LPMC_RUN   = 2'b00,
        LPMC_HALT  = 2'b01,
        LPMC_SLEEP = 2'b10,
        LPMC_RECOV = 2'b11
    } lpmc_mode_t;

    typedef struct packed {
        logic xtal_en;
        logic ipo_en;
        logic sys_clk_run;
        logic cpu_stall;
        logic pc_hold;
        logic wdt_osc_en;
        logic wdt_run;
        logic bod_en;
        logic cmp_en;
        logic vref_en;
        logic recov_rst;
    } lpmc_ctl_t;

endpackage

// ==== design/lpmc_top.sv ====
/*
 * Low-power mode controller: run, halt, deep sleep and deep-sleep recovery,
 * oscillator and clock gating, wake sources and the power control register.
 * Assumes sys_clk_i is the always-on controller clock, core requests are
 * one-cycle pulses on that clock, and GPIO and reset pins are asynchronous.
 */
// The APB register port was decided locally.
`timescale 1ns/100ps
module lpmc_top
    import lpmc_pkg::*;
#(
    parameter int GPIO_W      = 8,
    parameter int PERIPH_N    = 8,
    parameter int RECOV_CYC   = RECOV_OSC_CYC
) (
    input  wire logic                sys_clk_i,       // Always-on clock
    input  wire logic                rstn_i,          // Async reset, active low
    input  wire logic                psel_i,          // APB select
    input  wire logic                penable_i,       // APB enable
    input  wire logic                pwrite_i,        // APB write
    input  wire logic [11:0]         paddr_i,         // APB byte address
    input  wire logic [31:0]         pwdata_i,        // APB write data
    output logic      [31:0]         prdata_o,        // APB read data
    output logic                     pready_o,        // APB ready
    output logic                     pslverr_o,       // APB error
    input  wire logic                sleep_req_i,     // Core deep-sleep pulse
    input  wire logic                halt_req_i,      // Core halt pulse
    input  wire logic                irq_i,           // Pending interrupt
    input  wire logic                sys_exc_i,       // System exception
    input  wire logic                wdt_timeout_i,   // Watchdog time-out pulse
    input  wire logic                wdt_is_reset_i,  // Watchdog set to reset
    input  wire logic                wdt_en_i,        // Watchdog enabled
    input  wire logic                por_i,           // Power-on reset event
    input  wire logic                bod_rst_i,       // Brown-out reset event
    input  wire logic                bod_ao_opt_i,    // Brown-out always-on option
    input  wire logic                ext_rst_n_i,     // Reset pin, async
    input  wire logic [GPIO_W-1:0]   gpio_i,          // GPIO levels, async
    input  wire logic [PERIPH_N-1:0] periph_busy_i,   // Peripheral in use
    output lpmc_ctl_t                ctl_o,           // Clock and power controls
    output logic [PERIPH_N-1:0]      periph_clk_en_o, // Peripheral clock gates
    output logic                     xin_o,           // Crystal in drive value
    output logic                     xin_oe_o,        // Crystal in drive enable
    output logic                     crystal_out_pin_o,          // Crystal out drive value
    output logic                     crystal_out_pin_oe_o,       // Crystal out drive enable
    output logic                     wdt_exc_req_o,   // Exception after recovery
    output lpmc_mode_t               mode_o           // Current mode
);

    localparam int HRC = HALT_RECOV_CYC;
    localparam int RCV_LAST = RECOV_CYC - 1;
    localparam int CNT_W = $clog2(RECOV_CYC + 1);

    initial begin
        if (GPIO_W < 1 || GPIO_W > 32 || PERIPH_N < 1 || RECOV_CYC < 1) begin
            $error("lpmc_top: unsupported parameter value");
        end
    end

    // ==========================================================
    // Pin synchronisers
    logic [GPIO_W-1:0] gpio_s1_reg;
    logic [GPIO_W-1:0] gpio_s2_reg;
    logic [GPIO_W-1:0] gpio_prev_reg;
    logic              rst_s1_reg;
    logic              rst_s2_reg;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gpio_s1_reg   <= '0;
            gpio_s2_reg   <= '0;
            gpio_prev_reg <= '0;
            rst_s1_reg    <= 1'b1;
            rst_s2_reg    <= 1'b1;
        end else begin
            gpio_s1_reg   <= gpio_i;
            gpio_s2_reg   <= gpio_s1_reg;
            gpio_prev_reg <= gpio_s2_reg;
            rst_s1_reg    <= ext_rst_n_i;
            rst_s2_reg    <= rst_s1_reg;
        end
    end

    // ==========================================================
    // Registers
    logic [7:0]        pwr_ctl0_reg;
    logic [2:0]        opt_reg;
    logic [GPIO_W-1:0] wake_en_reg;
    logic              slp_flag_reg;
    logic              wdt_flag_reg;
    logic              wdt_exc_pend_reg;
    logic [CNT_W-1:0]  rcnt_reg;
    lpmc_mode_t        mode_reg;
    lpmc_mode_t        mode_next;

    wire wr_en   = psel_i && penable_i && pwrite_i;
    wire hit_pwr = (paddr_i == PWR_CTL0_OFF);
    wire hit_opt = (paddr_i == OPT_OFF);
    wire hit_st  = (paddr_i == STAT_OFF);
    wire hit_wen = (paddr_i == WAKE_EN_OFF);
    wire hit_any = hit_pwr || hit_opt || hit_st || hit_wen;

    // ==========================================================
    // Wake sources
    logic [GPIO_W-1:0] gpio_chg;
    genvar g;
    generate
        for (g = 0; g < GPIO_W; g++) begin : gen_chg
            assign gpio_chg[g] = wake_en_reg[g] && (gpio_s2_reg[g] != gpio_prev_reg[g]);
        end
    endgenerate

    wire gpio_wake   = |gpio_chg;
    wire wdt_slp_on  = opt_reg[OPT_WDT_SLP] && wdt_en_i;
    wire wdt_wake    = wdt_timeout_i && wdt_slp_on;
    wire sleep_wake  = gpio_wake || wdt_wake;
    wire halt_wake   = irq_i || sys_exc_i || wdt_timeout_i || por_i || bod_rst_i
                       || !rst_s2_reg;
    wire recov_done  = (rcnt_reg == CNT_W'(RECOV_CYC - 1));

    // ==========================================================
    // Mode machine
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            LPMC_RUN: begin
                if (sleep_req_i) begin
                    mode_next = LPMC_SLEEP;
                end else if (halt_req_i) begin
                    mode_next = LPMC_HALT;
                end
            end
            LPMC_HALT: begin
                if (halt_wake) begin
                    mode_next = LPMC_RUN;
                end
            end
            LPMC_SLEEP: begin
                if (sleep_wake) begin
                    mode_next = LPMC_RECOV;
                end
            end
            LPMC_RECOV: begin
                if (recov_done) begin
                    mode_next = LPMC_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_reg <= LPMC_RUN;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Recovery reset length counter
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rcnt_reg <= '0;
        end else if (mode_reg == LPMC_RECOV && !recov_done) begin
            rcnt_reg <= rcnt_reg + CNT_W'(1);
        end else begin
            rcnt_reg <= '0;
        end
    end

    // ==========================================================
    // Recovery status flags, set wins over clear
    wire slp_set = (mode_reg == LPMC_SLEEP) && sleep_wake;
    wire st_clr  = wr_en && hit_st;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            slp_flag_reg <= 1'b0;
            wdt_flag_reg <= 1'b0;
        end else begin
            if (slp_set) begin
                slp_flag_reg <= 1'b1;
            end else if (st_clr && pwdata_i[ST_SLP_RCV]) begin
                slp_flag_reg <= 1'b0;
            end
            if (slp_set && wdt_wake) begin
                wdt_flag_reg <= 1'b1;
            end else if (st_clr && pwdata_i[ST_WDT_RCV]) begin
                wdt_flag_reg <= 1'b0;
            end
        end
    end

    // Exception owed once recovery ends
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdt_exc_pend_reg <= 1'b0;
            wdt_exc_req_o    <= 1'b0;
        end else begin
            wdt_exc_req_o <= 1'b0;
            if (slp_set && wdt_wake && !wdt_is_reset_i) begin
                wdt_exc_pend_reg <= 1'b1;
            end else if (mode_reg == LPMC_RECOV && recov_done && wdt_exc_pend_reg) begin
                wdt_exc_pend_reg <= 1'b0;
                wdt_exc_req_o    <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Software registers, untouched by recovery
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwr_ctl0_reg <= PWR_CTL0_RST;
            opt_reg      <= OPT_RST;
            wake_en_reg  <= '0;
        end else if (wr_en) begin
            if (hit_pwr) begin
                pwr_ctl0_reg <= pwdata_i[7:0];
            end
            if (hit_opt) begin
                opt_reg <= pwdata_i[2:0];
            end
            if (hit_wen) begin
                wake_en_reg <= pwdata_i[GPIO_W-1:0];
            end
        end
    end

    // Read data captured in the setup cycle
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_pwr) begin
            rd_mux[7:0] = pwr_ctl0_reg;
        end else if (hit_opt) begin
            rd_mux[2:0] = opt_reg;
        end else if (hit_st) begin
            rd_mux[1:0]        = mode_reg;
            rd_mux[ST_SLP_RCV] = slp_flag_reg;
            rd_mux[ST_WDT_RCV] = wdt_flag_reg;
        end else if (hit_wen) begin
            rd_mux[GPIO_W-1:0] = wake_en_reg;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i) begin
            prdata_o <= rd_mux;
        end
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit_any;

    // ==========================================================
    // Clock, oscillator and power controls
    wire in_sleep = (mode_reg == LPMC_SLEEP);
    wire in_halt  = (mode_reg == LPMC_HALT);
    wire in_recov = (mode_reg == LPMC_RECOV);

    always_comb begin
        ctl_o.xtal_en     = !in_sleep;
        ctl_o.ipo_en      = !in_sleep;
        ctl_o.sys_clk_run = !in_sleep;
        ctl_o.cpu_stall   = in_sleep || in_halt || in_recov;
        ctl_o.pc_hold     = in_sleep || in_halt;
        ctl_o.wdt_osc_en  = in_sleep ? wdt_slp_on : 1'b1;
        ctl_o.wdt_run     = in_sleep ? wdt_slp_on : wdt_en_i;
        ctl_o.bod_en      = !pwr_ctl0_reg[BOD_DIS_BIT] && bod_ao_opt_i;
        ctl_o.cmp_en      = !opt_reg[OPT_CMP_DIS];
        ctl_o.vref_en     = !opt_reg[OPT_VREF_DIS];
        ctl_o.recov_rst   = in_recov;
    end

    // Gated by use; idle in sleep and recovery, normal in halt
    assign periph_clk_en_o = (in_sleep || in_recov) ? '0 : periph_busy_i;

    assign xin_o     = 1'b0;
    assign crystal_out_pin_o    = 1'b0;
    assign xin_oe_o  = in_sleep;
    assign crystal_out_pin_oe_o = in_sleep;
    assign mode_o    = mode_reg;

    // ==========================================================
    // Checks
    sleep_entry_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        mode_reg == LPMC_RUN && sleep_req_i |=> mode_reg == LPMC_SLEEP)
        else $error("deep sleep not entered");

    halt_entry_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        mode_reg == LPMC_RUN && halt_req_i && !sleep_req_i |=> mode_reg == LPMC_HALT)
        else $error("halt not entered");

    clk_stop_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        in_sleep |-> !ctl_o.sys_clk_run && !ctl_o.xtal_en && !ctl_o.ipo_en && xin_oe_o)
        else $error("clock or oscillator runs in deep sleep");

    pc_freeze_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (in_sleep || in_halt) |-> ctl_o.pc_hold && ctl_o.cpu_stall)
        else $error("core not stopped");

    halt_clock_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        in_halt |-> ctl_o.xtal_en && ctl_o.sys_clk_run && ctl_o.wdt_osc_en
                    && ctl_o.wdt_run == wdt_en_i)
        else $error("halt clocks wrong");

    halt_wake_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        in_halt && halt_wake |-> ##[1:HRC] mode_reg == LPMC_RUN)
        else $error("halt recovery too slow");

    sleep_stay_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        in_sleep && !sleep_wake |=> in_sleep)
        else $error("deep sleep left without recovery");

    recov_len_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(in_recov) |-> rcnt_reg == '0 ##RCV_LAST (in_recov && recov_done)
        ##1 mode_reg == LPMC_RUN)
        else $error("recovery length wrong");

    halt_periph_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        in_halt |-> periph_clk_en_o == periph_busy_i)
        else $error("peripheral gated in halt");

    exc_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wdt_exc_req_o |=> !wdt_exc_req_o && mode_reg == LPMC_RUN)
        else $error("exception request not a single pulse");

    recov_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        slp_set |=> slp_flag_reg && in_recov && ($past(wdt_wake) -> wdt_flag_reg))
        else $error("recovery flag not set");

    bod_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        ctl_o.bod_en == (!pwr_ctl0_reg[BOD_DIS_BIT] && bod_ao_opt_i))
        else $error("brown-out enable wrong");

    wdt_sleep_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        in_sleep && !opt_reg[OPT_WDT_SLP] |-> !ctl_o.wdt_run && !ctl_o.wdt_osc_en)
        else $error("watchdog runs in deep sleep");

    periph_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        in_sleep |-> periph_clk_en_o == '0)
        else $error("peripheral clocked in deep sleep");

endmodule

// ==== tb/lpmc_core_model.sv ====
/*
 * Core model: issues deep-sleep and halt instruction pulses, keeps a program counter.
 * Assumes the controller's control carrier and its always-on clock.
 */
`timescale 1ns/100ps
module lpmc_core_model
    import lpmc_pkg::*;
(
    input  wire logic      clk_i,     // Always-on clock
    input  wire logic      rstn_i,    // Reset, active low
    input  wire logic      do_slp_i,  // Bench asks for deep sleep
    input  wire logic      do_hlt_i,  // Bench asks for halt
    input  wire logic      ext_clk_i, // Running from an external clock
    input  wire lpmc_ctl_t ctl_i,     // Controls from the controller
    output logic           slp_o,     // Deep-sleep instruction pulse
    output logic           hlt_o,     // Halt instruction pulse
    output logic [15:0]    pc_o       // Program counter
);
    // ==========================================
    // Instruction issue and counter
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            slp_o <= 1'b0;
            hlt_o <= 1'b0;
            pc_o  <= 16'h0000;
        end else begin
            slp_o <= do_slp_i & !ext_clk_i;
            hlt_o <= do_hlt_i;
            if (ctl_i.sys_clk_run && !ctl_i.pc_hold && !ctl_i.recov_rst) begin
                pc_o <= pc_o + 16'h0001;
            end
        end
    end
endmodule

// ==== tb/tb_low_power_mode_controller.sv ====
/*
 * Bench for lpmc_top: APB registers, halt wake sources, deep sleep and recovery.
 * Assumes lpmc_pkg and lpmc_core_model are compiled first.
 */
`timescale 1ns/100ps
module tb_low_power_mode_controller
    import lpmc_pkg::*;
;
    localparam int RCV = 4;
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwd = 32'h0, prdata, rdv, me, mg;
    logic        pready, perr, err, slp, hlt, crystal_in_pin, xoe, crystal_out_pin, xooe, exc;
    logic        do_slp = 1'b0, do_hlt = 1'b0, ao = 1'b1;
    logic [5:0]  src = 6'h00;
    logic [7:0]  gpio = 8'h00, busy = 8'hFF, pclk, lf = 8'h0E;
    logic [15:0] pc, held;
    lpmc_ctl_t   ctl;
    lpmc_mode_t  mode;
    int          bad_count = 0, cmp_count = 0, n;
    logic [31:0] exp_q[$], got_q[$];
    event        got_e;

    lpmc_top #(.RECOV_CYC(RCV)) dut_u (.sys_clk_i(clk), .rstn_i(rstn), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(perr), .sleep_req_i(slp), .halt_req_i(hlt),
        .irq_i(src[0]), .sys_exc_i(src[1]), .wdt_timeout_i(src[2]), .wdt_is_reset_i(1'b0),
        .wdt_en_i(1'b1), .por_i(src[3]), .bod_rst_i(src[4]), .bod_ao_opt_i(ao),
        .ext_rst_n_i(!src[5]), .gpio_i(gpio), .periph_busy_i(busy), .ctl_o(ctl),
        .periph_clk_en_o(pclk), .xin_o(crystal_in_pin), .xin_oe_o(xoe), .crystal_out_pin_o(crystal_out_pin),
        .crystal_out_pin_oe_o(xooe), .wdt_exc_req_o(exc), .mode_o(mode));
    lpmc_core_model core_u (.clk_i(clk), .rstn_i(rstn), .do_slp_i(do_slp), .do_hlt_i(do_hlt),
        .ext_clk_i(1'b0), .ctl_i(ctl), .slp_o(slp), .hlt_o(hlt), .pc_o(pc));

    // ==========================================
    // Clock, scoreboard and helpers
    initial begin
        forever #25 clk = !clk;
    end

    always @(got_e) begin
        while (got_q.size() > 0) begin
            me = exp_q.pop_front();
            mg = got_q.pop_front();
            cmp_count++;
            if (mg !== me) begin
                bad_count++;
                $display("BAD t=%0t exp=%h got=%h", $time, me, mg);
            end
        end
    end

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic note(input logic [31:0] e, input logic [31:0] g);
        exp_q.push_back(e);
        got_q.push_back(g);
        ->got_e;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        note(e, rdv);
    endtask

    task automatic pulse(input logic s);
        @(posedge clk);
        if (s) do_slp <= 1'b1; else do_hlt <= 1'b1;
        @(posedge clk);
        do_slp <= 1'b0;
        do_hlt <= 1'b0;
    endtask

    task automatic wait_mode(input lpmc_mode_t m, input int lim);
        int i;
        i = 0;
        @(negedge clk);
        while (mode !== m && i < lim) begin
            @(negedge clk);
            i++;
        end
        note(m, mode);
    endtask

    task automatic recov(input logic owed);
        wait_mode(LPMC_RECOV, 6);
        n = 1;
        while (mode === LPMC_RECOV && n < 200) begin
            @(negedge clk);
            if (mode === LPMC_RECOV) n++;
        end
        note(RCV, n);
        note(owed, exc);
        @(negedge clk);
        note(0, exc);
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        test_done();
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rd(PWR_CTL0_OFF, PWR_CTL0_RST);
        rd(OPT_OFF, OPT_RST);
        rd(STAT_OFF, 32'h0);
        for (int k = 0; k < 6; k++) begin
            lf = lfsr(lf);
            @(posedge clk);
            ao <= lf[1];
            busy <= lf;
            apb(1'b1, PWR_CTL0_OFF, lf & 8'h10);
            rd(PWR_CTL0_OFF, lf & 8'h10);
            @(negedge clk);
            note(!lf[4] & lf[1], ctl.bod_en);
            note(lf, pclk);
        end
        rd(12'hF90, 32'h0);
        note(1, err);
        @(posedge clk);
        ao <= 1'b1;
        busy <= 8'hFF;
        apb(1'b1, PWR_CTL0_OFF, 32'h0);
        apb(1'b1, WAKE_EN_OFF, 32'h1);
        for (int k = 0; k < 6; k++) begin
            pulse(1'b0);
            wait_mode(LPMC_HALT, 6);
            note(11'h7FE, ctl);
            held = pc;
            @(posedge clk);
            src <= 6'h01 << k;
            @(negedge clk);
            note(held, pc);
            wait_mode(LPMC_RUN, HALT_RECOV_CYC - 2);
            @(posedge clk);
            src <= 6'h00;
            repeat (2) @(negedge clk);
            note(held + 16'h2, pc);
            repeat (3) @(posedge clk);
        end
        apb(1'b1, OPT_OFF, 32'h1);
        pulse(1'b1);
        wait_mode(LPMC_SLEEP, 6);
        note(11'h0FE, ctl);
        note({crystal_in_pin, xoe, crystal_out_pin, xooe, pclk}, 12'h500);
        @(posedge clk);
        src <= 6'h3B;
        repeat (5) @(negedge clk);
        note(LPMC_SLEEP, mode);
        @(posedge clk);
        src <= 6'h00;
        repeat (4) @(posedge clk);
        gpio[0] <= 1'b1;
        recov(1'b0);
        rd(STAT_OFF, 32'h4);
        apb(1'b1, STAT_OFF, 32'hC);
        rd(STAT_OFF, 32'h0);
        apb(1'b1, OPT_OFF, 32'h7);
        apb(1'b1, PWR_CTL0_OFF, 32'h10);
        pulse(1'b1);
        wait_mode(LPMC_SLEEP, 6);
        note(11'h0F0, ctl);
        @(posedge clk);
        src <= 6'h04;
        @(posedge clk);
        src <= 6'h00;
        recov(1'b1);
        rd(STAT_OFF, 32'hC);
        repeat (2) @(posedge clk);
        test_done();
    end
endmodule
